/* File: hw/gpio_mux_pkg.sv */
/*
 Shared constants and carriers for the port function mux with edge interrupts.
 Assumes a 16-bit register port and pins that are synchronous to the core clock.
*/
`default_nettype none
package gpio_mux_pkg;

    // port and pin geometry
    localparam int NUM_PORTS = 5;
    localparam int PORT_W = 10;
    localparam int NUM_PINS = 42;
    localparam int PIN_A = 0;
    localparam int PIN_B = 8;
    localparam int PIN_C = 16;
    localparam int PIN_D = 24;
    localparam int PIN_E = 32;
    localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PORT_MASK =
        {10'h3ff, 10'h0ff, 10'h0ff, 10'h0ff, 10'h0ff};

    // function select bit positions
    localparam int FSEL_UART = 0;
    localparam int FSEL_SERIAL = 1;
    localparam int FSEL_ADDR = 2;
    localparam int FSEL_DMA0 = 3;
    localparam int FSEL_DMA1 = 4;
    localparam int FSEL_PWM = 5;
    localparam int FSEL_WAIT = 6;
    localparam int FSEL_BUSDIR = 7;
    localparam int FSEL_SYNC_SERIAL_PORT = 8;
    localparam int FSEL_I2C = 9;
    localparam int FSEL_EXT_IRQ0 = 10;
    localparam int FSEL_FAST_IRQ = 14;
    localparam logic [15:0] FSEL_RESET = 16'h0000;
    localparam logic [15:0] FSEL_MASK = 16'h7fff;
    localparam logic [PORT_W-1:0] PORT_RESET = 10'h000;

    // register map: function select, then one 32-byte block per port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_FUNCTION_SELECT = 8'h00;
    localparam int PORT_BLOCK_SHIFT = 5;
    localparam logic [4:0] REG_PORT_OUT = 5'h00;
    localparam logic [4:0] REG_PORT_IN = 5'h04;
    localparam logic [4:0] REG_PORT_DIRECTION = 5'h08;
    localparam logic [4:0] REG_PORT_IRQ_ENABLE = 5'h0c;
    localparam logic [4:0] REG_PORT_EDGE_SELECT = 5'h10;
    localparam logic [4:0] REG_PORT_PENDING = 5'h14;

    // signals the peripherals drive toward the pins
    typedef struct packed {
        logic uart_sout;
        logic uart_dtr;
        logic uart_rts;
        logic serial_tx;
        logic [4:0] ext_addr_hi;
        logic dma_ch0_request_clear;
        logic dma_ch0_terminal_count;
        logic dma_ch1_request_clear;
        logic dma_ch1_terminal_count;
        logic pwm_channel_zero;
        logic pwm_channel_one;
        logic ext_bus_direction;
        logic sync_serial_clk;
        logic sync_serial_clk_drive;
        logic sync_serial_data_out;
        logic i2c_sda;
        logic i2c_sda_drive;
        logic i2c_scl;
        logic [6:0] dram_ctrl;
    } periph_out_s;

    // signals the pins feed to the peripherals
    typedef struct packed {
        logic uart_sin;
        logic uart_cts;
        logic uart_dsr;
        logic uart_dcd;
        logic uart_ri;
        logic serial_rx;
        logic dma_ch0_request;
        logic dma_ch1_request;
        logic ext_bus_wait;
        logic sync_serial_clk;
        logic sync_serial_data_in;
        logic i2c_sda;
        logic [3:0] external_irq_input;
        logic ext_fast_irq_low;
    } periph_in_s;

endpackage
`default_nettype wire

/* File: hw/port_edge_irq.sv */
/*
 Per-port edge detector with sticky pending flags and one request line.
 Assumes pin samples are synchronous to the clock; arm already folds in port mode.
*/
`timescale 1ns/1ps
`default_nettype none
module port_edge_irq #(
    parameter int WIDTH = 10
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] sample_in,
    input wire logic [WIDTH-1:0] arm_in,
    input wire logic [WIDTH-1:0] rise_sel_in,
    input wire logic [WIDTH-1:0] clear_in,
    output logic [WIDTH-1:0] pending_out,
    output logic irq_out
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] pending;
        logic irq;
    } edge_state_s;

    edge_state_s st;
    edge_state_s next_st;
    logic [WIDTH-1:0] hit;

    // per-bit edge select: 1 rising, 0 falling
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            assign hit[b] = arm_in[b] & (rise_sel_in[b] ?
                (sample_in[b] & ~st.prev[b]) : (~sample_in[b] & st.prev[b]));
        end
    endgenerate

    // set wins over a write-one clear in the same cycle
    always_comb begin
        next_st = st;
        next_st.prev = sample_in;
        next_st.pending = (st.pending & ~clear_in) | hit;
        next_st.irq = |next_st.pending;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pending_out = st.pending;
    assign irq_out = st.irq;
endmodule // port_edge_irq
`default_nettype wire

/* File: hw/pin_function_mux.sv */
/*
 Combinational pin router: picks port logic or a peripheral per pin group.
 Assumes the caller registers every result before it reaches a pin.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_function_mux (
    input wire logic [15:0] fsel_in,
    input wire logic dram_en_in,
    input wire logic [gpio_mux_pkg::NUM_PINS-1:0] port_out_in,
    input wire logic [gpio_mux_pkg::NUM_PINS-1:0] port_dir_in,
    input wire logic [gpio_mux_pkg::NUM_PINS-1:0] pin_in,
    input wire gpio_mux_pkg::periph_out_s from_periph_in,
    output logic [gpio_mux_pkg::NUM_PINS-1:0] secondary_out,
    output logic [gpio_mux_pkg::NUM_PINS-1:0] pin_val_out,
    output logic [gpio_mux_pkg::NUM_PINS-1:0] pin_drive_out,
    output gpio_mux_pkg::periph_in_s to_periph_out
);
    localparam int A = gpio_mux_pkg::PIN_A;
    localparam int B = gpio_mux_pkg::PIN_B;
    localparam int C = gpio_mux_pkg::PIN_C;
    localparam int D = gpio_mux_pkg::PIN_D;
    localparam int E = gpio_mux_pkg::PIN_E;

    // a cleared bit keeps port logic; a set bit hands the group over
    always_comb begin
        secondary_out = '0;
        pin_val_out = port_out_in;
        pin_drive_out = port_dir_in;
        to_periph_out = '0;
        to_periph_out.ext_fast_irq_low = 1'b1; // idle inactive when unrouted
        if (fsel_in[gpio_mux_pkg::FSEL_UART]) begin
            secondary_out[A+7:A] = 8'hff;
            pin_drive_out[A+7:A] = 8'h62;
            pin_val_out[A+1] = from_periph_in.uart_sout;
            pin_val_out[A+5] = from_periph_in.uart_dtr;
            pin_val_out[A+6] = from_periph_in.uart_rts;
            to_periph_out.uart_sin = pin_in[A+0];
            to_periph_out.uart_cts = pin_in[A+2];
            to_periph_out.uart_dsr = pin_in[A+3];
            to_periph_out.uart_dcd = pin_in[A+4];
            to_periph_out.uart_ri = pin_in[A+7];
        end
        if (fsel_in[gpio_mux_pkg::FSEL_SERIAL]) begin
            secondary_out[B+7:B+6] = 2'h3;
            pin_drive_out[B+7:B+6] = 2'h1;
            pin_val_out[B+6] = from_periph_in.serial_tx;
            to_periph_out.serial_rx = pin_in[B+7];
        end
        if (fsel_in[gpio_mux_pkg::FSEL_ADDR]) begin
            secondary_out[C+6:C+2] = 5'h1f;
            pin_drive_out[C+6:C+2] = 5'h1f;
            pin_val_out[C+6:C+2] = from_periph_in.ext_addr_hi;
        end
        if (fsel_in[gpio_mux_pkg::FSEL_DMA0]) begin
            secondary_out[B+1:B] = 2'h3;
            secondary_out[B+4] = 1'b1;
            pin_drive_out[B+1:B] = 2'h2;
            pin_drive_out[B+4] = 1'b1;
            pin_val_out[B+1] = from_periph_in.dma_ch0_request_clear;
            pin_val_out[B+4] = from_periph_in.dma_ch0_terminal_count;
            to_periph_out.dma_ch0_request = pin_in[B+0];
        end
        if (fsel_in[gpio_mux_pkg::FSEL_DMA1]) begin
            secondary_out[B+3:B+2] = 2'h3;
            secondary_out[B+5] = 1'b1;
            pin_drive_out[B+3:B+2] = 2'h2;
            pin_drive_out[B+5] = 1'b1;
            pin_val_out[B+3] = from_periph_in.dma_ch1_request_clear;
            pin_val_out[B+5] = from_periph_in.dma_ch1_terminal_count;
            to_periph_out.dma_ch1_request = pin_in[B+2];
        end
        if (fsel_in[gpio_mux_pkg::FSEL_PWM]) begin
            secondary_out[C+1:C] = 2'h3;
            pin_drive_out[C+1:C] = 2'h3;
            pin_val_out[C+0] = from_periph_in.pwm_channel_zero;
            pin_val_out[C+1] = from_periph_in.pwm_channel_one;
        end
        if (fsel_in[gpio_mux_pkg::FSEL_WAIT]) begin
            secondary_out[D+0] = 1'b1;
            pin_drive_out[D+0] = 1'b0;
            to_periph_out.ext_bus_wait = pin_in[D+0];
        end
        if (fsel_in[gpio_mux_pkg::FSEL_BUSDIR]) begin
            secondary_out[C+7] = 1'b1;
            pin_drive_out[C+7] = 1'b1;
            pin_val_out[C+7] = from_periph_in.ext_bus_direction;
        end
        if (fsel_in[gpio_mux_pkg::FSEL_SYNC_SERIAL_PORT]) begin
            secondary_out[E+2:E] = 3'h7;
            pin_drive_out[E+0] = from_periph_in.sync_serial_clk_drive;
            pin_drive_out[E+2:E+1] = 2'h2;
            pin_val_out[E+0] = from_periph_in.sync_serial_clk;
            pin_val_out[E+2] = from_periph_in.sync_serial_data_out;
            to_periph_out.sync_serial_clk = pin_in[E+0];
            to_periph_out.sync_serial_data_in = pin_in[E+1];
        end
        if (fsel_in[gpio_mux_pkg::FSEL_I2C]) begin
            secondary_out[E+4:E+3] = 2'h3;
            pin_drive_out[E+3] = from_periph_in.i2c_sda_drive;
            pin_drive_out[E+4] = 1'b1;
            pin_val_out[E+3] = from_periph_in.i2c_sda;
            pin_val_out[E+4] = from_periph_in.i2c_scl;
            to_periph_out.i2c_sda = pin_in[E+3];
        end
        // four independent external interrupt pins
        for (int i = 0; i < 4; i++) begin
            if (fsel_in[gpio_mux_pkg::FSEL_EXT_IRQ0+i]) begin
                secondary_out[E+5+i] = 1'b1;
                pin_drive_out[E+5+i] = 1'b0;
                to_periph_out.external_irq_input[i] = pin_in[E+5+i];
            end
        end
        if (fsel_in[gpio_mux_pkg::FSEL_FAST_IRQ]) begin
            secondary_out[E+9] = 1'b1;
            pin_drive_out[E+9] = 1'b0;
            to_periph_out.ext_fast_irq_low = pin_in[E+9];
        end
        // dram bank controls follow the strap, never the select register
        if (dram_en_in) begin
            secondary_out[D+7:D+1] = 7'h7f;
            pin_drive_out[D+7:D+1] = 7'h7f;
            pin_val_out[D+7:D+1] = from_periph_in.dram_ctrl;
        end
    end
endmodule // pin_function_mux
`default_nettype wire

/* File: hw/gpio_function_mux_edge_irq.sv */
/*
 Top of the pin function mux: register port, per-pin port control,
 pin output registers and five port interrupt request lines.
 Assumes pins and register strobes are synchronous to core_clk_in;
 the pad ring resolves pin levels from pin_out and pin_oe_low_out.
*/
// Notes on behaviour
// - select bit 4 gives port B DMA1 pins
// - select bit 5 drives PWM on C0, C1
// - select bit 6 makes D0 wait input
// - select bit 7 makes C7 bus direction
// - select bit 8 gives E0-E2 sync serial
// - select bit 9 gives E3 SDA, E4 SCL
// - bits 10-13 route E5-E8 to irq inputs
// - select bit 14 makes E9 fast irq
// - select 0 keeps port, 1 hands over
// - forty-two pins, ports A-D eight, E ten
// - per-pin direction, enable, polarity; 0 is input
// - port inputs usable as edge interrupts
// - armed input edge sets its pending bit
// - pending bit raises its port request line
// - select bit 0 gives port A UART
// - dram strap switches D1-D7, not select
// - polarity 0 falling, 1 rising edge
// - write one clears pending; reset clears all
// - select register read/write, resets to zero
`timescale 1ns/1ps
`default_nettype none
module gpio_function_mux_edge_irq (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [gpio_mux_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [gpio_mux_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [gpio_mux_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic dram_enable_strap_low_in,
    input wire logic [gpio_mux_pkg::NUM_PINS-1:0] pin_in,
    output logic [gpio_mux_pkg::NUM_PINS-1:0] pin_out,
    output logic [gpio_mux_pkg::NUM_PINS-1:0] pin_oe_low_out,
    input wire gpio_mux_pkg::periph_out_s from_periph_in,
    output gpio_mux_pkg::periph_in_s to_periph_out,
    output logic [gpio_mux_pkg::NUM_PORTS-1:0] port_irq_request_out
);
    localparam int NP = gpio_mux_pkg::NUM_PORTS;
    localparam int PW = gpio_mux_pkg::PORT_W;
    localparam int NPIN = gpio_mux_pkg::NUM_PINS;

    // every piece of state of the top except the edge engines in one register
    typedef struct packed {
        logic [15:0] fsel;
        logic dram_en;
        logic strap_done;
        logic [NP-1:0][PW-1:0] port_out;
        logic [NP-1:0][PW-1:0] port_direction_bits;
        logic [NP-1:0][PW-1:0] port_irq_enable_bits;
        logic [NP-1:0][PW-1:0] port_irq_edge_select;
        logic [NPIN-1:0] pin_val;
        logic [NPIN-1:0] pin_oe_low;
        gpio_mux_pkg::periph_in_s to_periph;
        logic [gpio_mux_pkg::DATA_W-1:0] rdata;
    } top_state_s;

    top_state_s st;
    top_state_s next_st;

    // flattened port control as seen by the pin router
    logic [NPIN-1:0] flat_out;
    logic [NPIN-1:0] flat_dir;
    logic [NPIN-1:0] secondary;
    logic [NPIN-1:0] mux_val;
    logic [NPIN-1:0] mux_drive;
    gpio_mux_pkg::periph_in_s mux_periph;

    // register decode
    logic [2:0] blk;
    logic [2:0] pidx;
    logic port_hit;
    logic [4:0] sub;
    logic [NP-1:0][PW-1:0] pend_clear;
    logic [NP-1:0][PW-1:0] pending;
    logic [NP-1:0][PW-1:0] arm;
    logic [NP-1:0][PW-1:0] sample;

    assign blk = reg_addr_in[gpio_mux_pkg::ADDR_W-1:gpio_mux_pkg::PORT_BLOCK_SHIFT];
    assign pidx = blk - 3'h1;
    assign port_hit = (blk != 3'h0) && (blk <= 3'(NP));
    assign sub = reg_addr_in[gpio_mux_pkg::PORT_BLOCK_SHIFT-1:0];

    // per-port flattening, arming and interrupt engines
    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            localparam int BASE = p * 8;
            localparam int W = (p == NP - 1) ? PW : 8;
            assign flat_out[BASE+W-1:BASE] = st.port_out[p][W-1:0];
            assign flat_dir[BASE+W-1:BASE] = st.port_direction_bits[p][W-1:0];
            assign sample[p] = PW'(pin_in[BASE+W-1:BASE]);
            // only port-mode inputs with interrupts enabled may fire
            assign arm[p] = PW'(~secondary[BASE+W-1:BASE] & ~flat_dir[BASE+W-1:BASE])
                & st.port_irq_enable_bits[p] & gpio_mux_pkg::PORT_MASK[p];
            assign pend_clear[p] = (reg_write_in && port_hit && pidx == 3'(p)
                && sub == gpio_mux_pkg::REG_PORT_PENDING)
                ? (reg_wdata_in[PW-1:0] & gpio_mux_pkg::PORT_MASK[p]) : '0;
            port_edge_irq #(
                .WIDTH(PW)
            ) u_edge (
                .core_clk_in(core_clk_in),
                .rst_in(rst_in),
                .sample_in(sample[p]),
                .arm_in(arm[p]),
                .rise_sel_in(st.port_irq_edge_select[p]),
                .clear_in(pend_clear[p]),
                .pending_out(pending[p]),
                .irq_out(port_irq_request_out[p])
            );
        end
    endgenerate

    pin_function_mux u_mux (
        .fsel_in(st.fsel),
        .dram_en_in(st.dram_en),
        .port_out_in(flat_out),
        .port_dir_in(flat_dir),
        .pin_in(pin_in),
        .from_periph_in(from_periph_in),
        .secondary_out(secondary),
        .pin_val_out(mux_val),
        .pin_drive_out(mux_drive),
        .to_periph_out(mux_periph)
    );

    // next state: strap capture, pins, register writes and reads
    always_comb begin
        next_st = st;
        next_st.rdata = '0; // read data stands one cycle only
        // strap sampled on the first edge after reset release
        if (!st.strap_done) begin
            next_st.dram_en = ~dram_enable_strap_low_in;
            next_st.strap_done = 1'b1;
        end
        // registered pins cost one cycle but keep outputs glitch free
        next_st.pin_val = mux_val;
        next_st.pin_oe_low = ~mux_drive;
        next_st.to_periph = mux_periph;
        if (reg_write_in) begin
            if (reg_addr_in == gpio_mux_pkg::REG_FUNCTION_SELECT) begin
                next_st.fsel = reg_wdata_in & gpio_mux_pkg::FSEL_MASK;
            end else if (port_hit) begin
                unique case (sub)
                    gpio_mux_pkg::REG_PORT_OUT: begin
                        next_st.port_out[pidx] =
                            reg_wdata_in[PW-1:0] & gpio_mux_pkg::PORT_MASK[pidx];
                    end
                    gpio_mux_pkg::REG_PORT_DIRECTION: begin
                        next_st.port_direction_bits[pidx] =
                            reg_wdata_in[PW-1:0] & gpio_mux_pkg::PORT_MASK[pidx];
                    end
                    gpio_mux_pkg::REG_PORT_IRQ_ENABLE: begin
                        next_st.port_irq_enable_bits[pidx] =
                            reg_wdata_in[PW-1:0] & gpio_mux_pkg::PORT_MASK[pidx];
                    end
                    gpio_mux_pkg::REG_PORT_EDGE_SELECT: begin
                        next_st.port_irq_edge_select[pidx] =
                            reg_wdata_in[PW-1:0] & gpio_mux_pkg::PORT_MASK[pidx];
                    end
                    default: begin
                        // input, pending (cleared in engine) and holes
                    end
                endcase
            end
        end
        if (reg_read_in) begin
            if (reg_addr_in == gpio_mux_pkg::REG_FUNCTION_SELECT) begin
                next_st.rdata = st.fsel;
            end else if (port_hit) begin
                unique case (sub)
                    gpio_mux_pkg::REG_PORT_OUT: begin
                        next_st.rdata = 16'(st.port_out[pidx]);
                    end
                    gpio_mux_pkg::REG_PORT_IN: begin
                        next_st.rdata = 16'(sample[pidx] & gpio_mux_pkg::PORT_MASK[pidx]);
                    end
                    gpio_mux_pkg::REG_PORT_DIRECTION: begin
                        next_st.rdata = 16'(st.port_direction_bits[pidx]);
                    end
                    gpio_mux_pkg::REG_PORT_IRQ_ENABLE: begin
                        next_st.rdata = 16'(st.port_irq_enable_bits[pidx]);
                    end
                    gpio_mux_pkg::REG_PORT_EDGE_SELECT: begin
                        next_st.rdata = 16'(st.port_irq_edge_select[pidx]);
                    end
                    gpio_mux_pkg::REG_PORT_PENDING: begin
                        next_st.rdata = 16'(pending[pidx]);
                    end
                    default: begin
                        next_st.rdata = '0; // unmapped reads return zero
                    end
                endcase
            end
        end
    end

    // reset: all pins port-mode inputs, nothing driven
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
            st.fsel <= gpio_mux_pkg::FSEL_RESET;
            st.port_direction_bits <= {NP{gpio_mux_pkg::PORT_RESET}};
            st.pin_oe_low <= '1;
            st.to_periph.ext_fast_irq_low <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign pin_out = st.pin_val;
    assign pin_oe_low_out = st.pin_oe_low;
    assign to_periph_out = st.to_periph;
endmodule // gpio_function_mux_edge_irq
`default_nettype wire

/* File: bench/gpio_mux_checker_asserts.sv */
/*
 Port checker for the pin function mux top.
 Assumes a bind from the bench top; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_mux_checker (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic [41:0] pin_in,
    input wire logic [41:0] pin_out,
    input wire logic [41:0] pin_oe_low_out,
    input wire gpio_mux_pkg::periph_out_s from_periph_in,
    input wire gpio_mux_pkg::periph_in_s to_periph_out,
    input wire logic [4:0] port_irq_request_out
);
    logic [15:0] fsel_seen;
    // shadow of the select register, built from writes only
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fsel_seen <= 16'h0000;
        end else if (reg_write_in && reg_addr_in == 8'h00) begin
            fsel_seen <= reg_wdata_in & 16'h7fff;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    rdata_idle_a: assert property (!$past(reg_read_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data outside its slot");
    select_read_a: assert property (reg_read_in && reg_addr_in == 8'h00 |=> reg_rdata_out == fsel_seen)
        else $error("select register read mismatch");
    reset_inputs_a: assert property ($fell(rst_in) |-> &pin_oe_low_out && port_irq_request_out == 5'h00)
        else $error("pins not released after reset");
    pwm_route_a: assert property (fsel_seen[5] |=> !pin_oe_low_out[16] && pin_out[16] == $past(from_periph_in.pwm_channel_zero))
        else $error("pwm not on port c pin 0");
    busdir_route_a: assert property (fsel_seen[7] |=> !pin_oe_low_out[23] && pin_out[23] == $past(from_periph_in.ext_bus_direction))
        else $error("bus direction not on port c pin 7");
    dma_request_a: assert property (fsel_seen[4] |=> to_periph_out.dma_ch1_request == $past(pin_in[10]))
        else $error("dma request not from port b pin 2");
    fast_irq_idle_a: assert property (!fsel_seen[14] |=> to_periph_out.ext_fast_irq_low)
        else $error("fast irq not idle");
    irq_cause_a: assert property ($rose(port_irq_request_out[0]) |-> $past(pin_in[7:0]) != $past(pin_in[7:0], 2))
        else $error("port a request without pin edge");
    irq_hold_a: assert property (port_irq_request_out[0] && !reg_write_in |=> port_irq_request_out[0])
        else $error("port a request dropped");
    irq_clear_a: assert property ($fell(port_irq_request_out[0]) |-> $past(reg_write_in) || $past(reg_write_in, 2))
        else $error("port a request fell without write");
endmodule // gpio_mux_checker
`default_nettype wire

/* File: bench/pin_world_model.sv */
/*
 Far side: pads that take the far level when undriven and peripherals driving a changing pattern.
 Assumes levels are given by the bench, clocked by the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_world_model (
    input wire logic core_clk_in,
    input wire logic [41:0] far_level_in,
    input wire logic [41:0] pin_out_in,
    input wire logic [41:0] pin_oe_low_in,
    output logic [41:0] pin_level_out,
    output gpio_mux_pkg::periph_out_s from_periph_out
);
    logic [$bits(gpio_mux_pkg::periph_out_s)-1:0] pattern = '0;
    // pattern moves every cycle so a stuck route shows
    always_ff @(posedge core_clk_in) begin
        pattern <= pattern + 1'b1;
    end
    assign from_periph_out = pattern;
    // the chip wins where it drives, else the far level
    assign pin_level_out = (pin_oe_low_in & far_level_in) | (~pin_oe_low_in & pin_out_in);
endmodule // pin_world_model
`default_nettype wire

/* File: bench/gpio_function_mux_edge_irq_bench.sv */
/*
 Register-driven bench for the pin function mux with edge interrupts.
 Assumes the far-side model and checker files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_function_mux_edge_irq_bench;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic strap_low = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [15:0] rdata;
    logic [41:0] far = '1;
    logic [41:0] pin_lvl;
    logic [41:0] pin_o;
    logic [41:0] oe_low;
    gpio_mux_pkg::periph_out_s periph;
    gpio_mux_pkg::periph_in_s to_per;
    logic [4:0] irq;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    initial begin
        forever #5 core_clk_in = ~core_clk_in;
    end
    gpio_function_mux_edge_irq i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_stb), .reg_read_in(rd_stb),
        .reg_rdata_out(rdata), .dram_enable_strap_low_in(strap_low), .pin_in(pin_lvl),
        .pin_out(pin_o), .pin_oe_low_out(oe_low), .from_periph_in(periph),
        .to_periph_out(to_per), .port_irq_request_out(irq));
    pin_world_model i_far (.core_clk_in(core_clk_in), .far_level_in(far), .pin_out_in(pin_o),
        .pin_oe_low_in(oe_low), .pin_level_out(pin_lvl), .from_periph_out(periph));
    task automatic chk(input string what, input logic [41:0] exp, input logic [41:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk_in);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk_in);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk_in);
        rd_stb <= 1'b0;
        #1 chk(what, 42'(exp), 42'(rdata));
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // hang guard, the whole run needs under a hundred cycles
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd("select", 8'h00, 16'h0000);
        rd("pending a", 8'h34, 16'h0000);
        chk("oe at reset", '1, oe_low);
        // every select group handed over, dram pins stay with the strap; reserved top bit reads zero
        wr(8'h00, 16'hffff);
        far[41:37] <= 5'b01010;
        rd("select", 8'h00, 16'h7fff);
        repeat (2) @(posedge core_clk_in);
        #1 chk("fast irq", 42'(1'b0), 42'(to_per.ext_fast_irq_low));
        chk("ext irq", 42'(4'b1010), 42'(to_per.external_irq_input));
        chk("dma req", 42'(1'b1), 42'(to_per.dma_ch1_request));
        chk("wait", 42'(1'b1), 42'(to_per.ext_bus_wait));
        chk("out oe", 42'(7'h00), 42'({oe_low[1], oe_low[16], oe_low[23], oe_low[34],
            oe_low[36], oe_low[11], oe_low[13]}));
        chk("dram pins", 42'(7'h7f), 42'(oe_low[31:25]));
        wr(8'h00, 16'h0000);
        repeat (2) @(posedge core_clk_in);
        #1 chk("oe released", '1, oe_low);
        // falling then rising trigger on port a pin 0
        for (int p = 0; p < 2; p++) begin
            wr(8'h30, 16'(p));
            far[0] <= ~p[0];
            wr(8'h2c, 16'h0001);
            far[0] <= p[0];
            repeat (3) @(posedge core_clk_in);
            #1 chk("irq a", 42'(1'b1), 42'(irq[0]));
            rd("pending a", 8'h34, 16'h0001);
            wr(8'h34, 16'h0000);
            rd("pending kept", 8'h34, 16'h0001);
            wr(8'h34, 16'h0001);
            rd("pending cleared", 8'h34, 16'h0000);
            chk("irq a off", 42'(1'b0), 42'(irq[0]));
        end
        // edges on a uart pin are not port events
        wr(8'h00, 16'h0001);
        far[0] <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        far[0] <= 1'b1;
        rd("secondary edge", 8'h34, 16'h0000);
        // a driven output rising is not a port event
        wr(8'h00, 16'h0000);
        wr(8'h28, 16'h0001);
        wr(8'h20, 16'h0001);
        rd("output edge", 8'h34, 16'h0000);
        chk("pin a0 out", 42'(2'b01), 42'({oe_low[0], pin_o[0]}));
        // strap low over a new reset: dram owns d1-d7
        @(posedge core_clk_in);
        strap_low <= 1'b0;
        rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        #1 chk("dram on", 42'(7'h00), 42'(oe_low[31:25]));
        summarize();
    end
endmodule // gpio_function_mux_edge_irq_bench
bind gpio_function_mux_edge_irq gpio_mux_checker i_chk (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_low_out(pin_oe_low_out),
    .from_periph_in(from_periph_in), .to_periph_out(to_periph_out),
    .port_irq_request_out(port_irq_request_out));
`default_nettype wire
